// ### include/gpio_port_pkg.sv
// constants and types shared by the port A gpio block
package gpio_port_pkg;
    localparam int PIN_COUNT = 8;
    localparam logic [11:0] OFFSET_DIRECTION = 12'h000;
    localparam logic [11:0] OFFSET_LEVEL = 12'h004;
    localparam logic [11:0] OFFSET_LATCH = 12'h008;
    localparam logic [11:0] OFFSET_CONFIG = 12'h00c;
    localparam logic [7:0] DIRECTION_RESET = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    // pins 0,1,4,5 start analog
    localparam logic [7:0] ANALOG_RESET = 8'h33;
    localparam logic [7:0] OSC_PIN_MASK = 8'hc0;
    // config register fields
    localparam int CFG_ANALOG_LSB = 0;
    localparam int CFG_OSC_BIT = 8;
    localparam int CFG_FAULT_BIT = 9;
    localparam int CFG_PERIPH_LSB = 16;
    localparam logic [31:0] CFG_RESET = 32'h0000_0033;
    localparam int FAULT_PIN_LOW = 5;
    localparam int FAULT_PIN_HIGH = 7;
    localparam int TX_PIN = 2;
    localparam int RX_PIN = 3;
    localparam int TMR_PIN = 4;
    typedef enum logic [1:0] {
        REG_DIRECTION,
        REG_LEVEL,
        REG_LATCH,
        REG_CONFIG
    } reg_sel_t;
endpackage

// ### include/port_regs_if.sv
// register values handed from the register file to the pin logic
interface port_regs_if;
    logic [7:0] direction;
    logic [7:0] latch;
    logic [7:0] analogSel;
    logic [7:0] periphEnable;
    logic [7:0] periphOut;
    logic [7:0] periphOe;
    logic oscMode;
    logic faultHigh;
    logic [7:0] levels;
    modport regs (output direction, latch, analogSel, periphEnable, oscMode, faultHigh,
        input levels);
    modport pins (input direction, latch, analogSel, periphEnable, oscMode, faultHigh,
        periphOut, periphOe, output levels);
    modport periph (output periphOut, periphOe);
endinterface

// ### core/port_reg_file.sv
// apb register file for port A
module port_reg_file (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pslverr,
    // to pin logic
    port_regs_if.regs regs
);
    logic [7:0] direction;
    logic [7:0] next_direction;
    logic [7:0] latch;
    logic [7:0] next_latch;
    logic [31:0] cfgWord;
    logic [31:0] next_cfgWord;
    logic [31:0] next_prdata;
    logic [7:0] hidden;
    logic access;
    logic setup;

    function automatic logic [31:0] widen(input logic [7:0] v);
        return {24'h000000, v};
    endfunction

    assign access = psel && penable;
    // read data is loaded in the setup cycle so it stands at the access edge
    assign setup = psel && !penable;
    assign pslverr = 1'b0;
    // oscillator pins hide direction and latch bits
    assign hidden = cfgWord[gpio_port_pkg::CFG_OSC_BIT] ? gpio_port_pkg::OSC_PIN_MASK : 8'h00;

    always_comb begin
        next_direction = direction;
        next_latch = latch;
        next_cfgWord = cfgWord;
        next_prdata = prdata;
        if (access && pwrite) begin
            unique case (paddr)
                gpio_port_pkg::OFFSET_DIRECTION: next_direction = pwdata[7:0];
                gpio_port_pkg::OFFSET_LEVEL: next_latch = pwdata[7:0];
                gpio_port_pkg::OFFSET_LATCH: next_latch = pwdata[7:0];
                gpio_port_pkg::OFFSET_CONFIG: next_cfgWord = pwdata;
                default: next_latch = latch;
            endcase
        end
        if (setup && !pwrite) begin
            unique case (paddr)
                gpio_port_pkg::OFFSET_DIRECTION: next_prdata = widen(direction & ~hidden);
                gpio_port_pkg::OFFSET_LEVEL: next_prdata = widen(regs.levels);
                gpio_port_pkg::OFFSET_LATCH: next_prdata = widen(latch & ~hidden);
                gpio_port_pkg::OFFSET_CONFIG: next_prdata = cfgWord;
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            direction <= gpio_port_pkg::DIRECTION_RESET;
            latch <= gpio_port_pkg::LATCH_RESET;
            cfgWord <= gpio_port_pkg::CFG_RESET;
            prdata <= 32'h00000000;
        end else begin
            direction <= next_direction;
            latch <= next_latch;
            cfgWord <= next_cfgWord;
            prdata <= next_prdata;
        end
    end

    assign regs.direction = direction;
    assign regs.latch = latch;
    assign regs.analogSel = cfgWord[gpio_port_pkg::CFG_ANALOG_LSB +: 8];
    assign regs.periphEnable = cfgWord[gpio_port_pkg::CFG_PERIPH_LSB +: 8];
    assign regs.oscMode = cfgWord[gpio_port_pkg::CFG_OSC_BIT];
    assign regs.faultHigh = cfgWord[gpio_port_pkg::CFG_FAULT_BIT];
endmodule

// ### core/port_pin_mux.sv
// per-pin direction, drive and read-back logic for port A
module port_pin_mux (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register values
    port_regs_if.pins regs,
    // pins
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    output logic [7:0] digitalIn
);
    logic [7:0] sampled;
    logic [7:0] next_sampled;
    logic [7:0] usable;

    assign usable = regs.oscMode ? ~gpio_port_pkg::OSC_PIN_MASK : 8'hff;

    always_comb begin
        // analog pins read zero, oscillator pins read zero
        next_sampled = pinIn & ~regs.analogSel & usable;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sampled <= 8'h00;
        end else begin
            sampled <= next_sampled;
        end
    end

    always_comb begin
        for (int i = 0; i < gpio_port_pkg::PIN_COUNT; i++) begin
            if (regs.periphEnable[i]) begin
                pinOut[i] = regs.periphOut[i];
                pinOe[i] = regs.periphOe[i] && usable[i];
            end else begin
                pinOut[i] = regs.latch[i];
                // direction bit governs even analog pins
                pinOe[i] = !regs.direction[i] && usable[i];
            end
        end
    end

    assign regs.levels = sampled;
    assign digitalIn = sampled;
endmodule

// ### core/port_a_gpio.sv
// top of the port A general purpose io block with apb registers
// What this block does
// - eight pins, each with direction, level, latch bits
// - direction one makes pin input, driver off
// - direction zero drives the latch value out
// - level read gives pins, write sets latch
// - latch register reads back the latched value
// - oscillator mode hides pins six, seven
// - fault input from pin five or seven
// - reset makes 0,1,4,5 analog, 2,3 digital
// - direction bits still rule analog pins
// - enabled peripheral takes its pin over
// - pin zero feeds analog, irq, change, comparator
// - pin one feeds analog, irq, change
// - pins two, three carry serial tx, rx
// - pin four feeds timer clock, analog, reference
module port_a_gpio (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    // peripheral sources
    input wire logic serialTx,
    input wire logic serialTxEnable,
    // peripheral sinks
    output logic analogInputZero,
    output logic analogInputOne,
    output logic analogInputTwo,
    output logic externalIrqZero,
    output logic externalIrqOne,
    output logic changeIrqZero,
    output logic changeIrqOne,
    output logic comparatorInputZero,
    output logic timerZeroClockIn,
    output logic referenceInput,
    output logic serialRx,
    output logic pwmFaultInput
);
    port_regs_if regsBus();
    logic [7:0] digitalIn;
    logic [7:0] raw;
    logic [7:0] next_raw;
    logic [7:0] periphOutValue;
    logic [7:0] periphOeValue;

    assign pready = 1'b1;

    port_reg_file regFile (
        .clk(clk),
        .reset(reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pslverr(pslverr),
        .regs(regsBus.regs)
    );

    port_pin_mux pinMux (
        .clk(clk),
        .reset(reset),
        .regs(regsBus.pins),
        .pinIn(pinIn),
        .pinOut(pinOut),
        .pinOe(pinOe),
        .digitalIn(digitalIn)
    );

    always_comb begin
        periphOutValue = 8'h00;
        periphOeValue = 8'h00;
        periphOutValue[gpio_port_pkg::TX_PIN] = serialTx;
        periphOeValue[gpio_port_pkg::TX_PIN] = serialTxEnable;
    end
    assign regsBus.periphOut = periphOutValue;
    assign regsBus.periphOe = periphOeValue;

    // analog paths see the unmasked pin levels
    always_comb begin
        next_raw = pinIn;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            raw <= 8'h00;
        end else begin
            raw <= next_raw;
        end
    end

    assign analogInputZero = raw[0];
    assign externalIrqZero = digitalIn[0];
    assign changeIrqZero = digitalIn[0];
    assign comparatorInputZero = raw[0];
    assign analogInputOne = raw[1];
    assign externalIrqOne = digitalIn[1];
    assign changeIrqOne = digitalIn[1];
    assign serialRx = digitalIn[gpio_port_pkg::RX_PIN];
    assign timerZeroClockIn = digitalIn[gpio_port_pkg::TMR_PIN];
    assign analogInputTwo = raw[gpio_port_pkg::TMR_PIN];
    assign referenceInput = raw[gpio_port_pkg::TMR_PIN];
    assign pwmFaultInput = regsBus.faultHigh ? raw[gpio_port_pkg::FAULT_PIN_HIGH]
        : raw[gpio_port_pkg::FAULT_PIN_LOW];
endmodule

// ### tb/pin_world.sv
// outside circuitry on the port pins
module pin_world (
    // port side
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    // outside drive
    input wire logic [7:0] ext,
    // level seen by the port
    output logic [7:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // driven pins follow the port, released pins follow the outside load
    assign pinIn = (pinOut & pinOe) | (ext & ~pinOe);
endmodule

// ### tb/port_a_gpio_chk.sv
// assertions on the port A gpio top ports
module port_a_gpio_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and sinks
    input wire logic [7:0] pinIn,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic analogInputZero,
    input wire logic analogInputOne,
    input wire logic externalIrqZero,
    input wire logic externalIrqOne,
    input wire logic changeIrqZero,
    input wire logic changeIrqOne,
    input wire logic analogInputTwo,
    input wire logic comparatorInputZero,
    input wire logic referenceInput,
    input wire logic pwmFaultInput
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence wrAt(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    a_reset_inputs: assert property ($fell(reset) |-> pinOe == 8'h00)
        else $error("pins driven after reset");
    a_access_ok: assert property (pready && !pslverr)
        else $error("access not answered");
    a_level_write: assert property (wrAt(12'h004) |=> pinOut[1:0] == $past(pwdata[1:0]))
        else $error("level write missed latch");
    a_latch_write: assert property (wrAt(12'h008) |=> pinOut[1:0] == $past(pwdata[1:0]))
        else $error("latch write missed pins");
    a_dir_input: assert property (wrAt(12'h000) ##0 pwdata[1:0] == 2'b11 |=> pinOe[1:0] == 2'b00)
        else $error("input pin still driven");
    a_dir_output: assert property (wrAt(12'h000) ##0 pwdata[1:0] == 2'b00 |=> pinOe[1:0] == 2'b11)
        else $error("output pin not driven");
    a_read_upper: assert property (psel && penable && !pwrite |=> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_fault_src: assert property (!$past(reset) |-> pwmFaultInput == $past(pinIn[5]) || pwmFaultInput == $past(pinIn[7]))
        else $error("fault input from wrong pin");
    a_analog_raw: assert property (!$past(reset) |-> analogInputZero == $past(pinIn[0]) && comparatorInputZero == $past(pinIn[0]))
        else $error("pin zero sinks wrong");
    a_ref_raw: assert property (!$past(reset) |-> referenceInput == $past(pinIn[4]) && analogInputTwo == $past(pinIn[4]))
        else $error("pin four sinks wrong");
    a_pin_one_raw: assert property (!$past(reset) |-> analogInputOne == $past(pinIn[1]))
        else $error("pin one analog sink wrong");
    a_irq_follow: assert property (!$past(reset) |-> (!externalIrqZero || $past(pinIn[0]))
        && (!externalIrqOne || $past(pinIn[1])) && changeIrqZero == externalIrqZero
        && changeIrqOne == externalIrqOne)
        else $error("irq sinks do not follow pins");
endmodule
bind port_a_gpio port_a_gpio_chk chk (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOe, .analogInputZero, .analogInputOne,
    .externalIrqZero, .externalIrqOne, .changeIrqZero, .changeIrqOne, .analogInputTwo,
    .comparatorInputZero, .referenceInput, .pwmFaultInput);

// ### tb/test_port_a_gpio.sv
// bench for the port A gpio block
module test_port_a_gpio;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] DIR = gpio_port_pkg::OFFSET_DIRECTION;
    localparam logic [11:0] LVL = gpio_port_pkg::OFFSET_LEVEL;
    localparam logic [11:0] LAT = gpio_port_pkg::OFFSET_LATCH;
    localparam logic [11:0] CFG = gpio_port_pkg::OFFSET_CONFIG;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, serialTx = 0, serialTxEnable = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, eZ, tmr, rx, flt;
    logic [7:0] pinIn, pinOut, pinOe, ext = 8'hff;
    int errors = 0, checked = 0;
    always #2.5 clk = ~clk;
    port_a_gpio uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .serialTx(serialTx),
        .serialTxEnable(serialTxEnable), .analogInputZero(), .analogInputOne(),
        .analogInputTwo(), .externalIrqZero(eZ), .externalIrqOne(), .changeIrqZero(),
        .changeIrqOne(), .comparatorInputZero(), .timerZeroClockIn(tmr), .referenceInput(),
        .serialRx(rx), .pwmFaultInput(flt));
    pin_world far (.pinOut(pinOut), .pinOe(pinOe), .ext(ext), .pinIn(pinIn));
    task conclude;
        if (errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task checkReg(input logic [31:0] a, input logic [31:0] e);
        checked++;
        if (a !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task checkPin(input logic [7:0] a, input logic [7:0] e);
        checkReg({24'h0, a}, {24'h0, e});
    endtask
    // one apb transfer; read data is taken at the edge that sees pready high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdChk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        checkReg(rd, e);
    endtask
    task resetValues;
        checkPin(pinOe, 8'h00);
        rdChk(DIR, 32'hff);
        rdChk(LAT, 32'h0);
        rdChk(LVL, 32'hcc);
    endtask
    task driveOut;
        wr(CFG, 32'h0);
        wr(DIR, 32'h0);
        wr(LVL, 32'ha5);
        rdChk(LAT, 32'ha5);
        checkPin(pinOut, 8'ha5);
        checkPin(pinOe, 8'hff);
        rdChk(LVL, 32'ha5);
        wr(LAT, 32'h3c);
        rdChk(LAT, 32'h3c);
        rdChk(LVL, 32'h3c);
    endtask
    task readIn;
        ext <= 8'h5a;
        wr(DIR, 32'hff);
        checkPin(pinOe, 8'h00);
        rdChk(LVL, 32'h5a);
        wr(CFG, 32'h33);
        rdChk(LVL, 32'h48);
        wr(DIR, 32'hcc);
        checkPin(pinOe, 8'h33);
        wr(DIR, 32'hff);
    endtask
    task oscMode;
        wr(LAT, 32'hff);
        wr(CFG, 32'h100);
        rdChk(DIR, 32'h3f);
        rdChk(LAT, 32'h3f);
        rdChk(LVL, 32'h1a);
    endtask
    task faultSel;
        ext <= 8'h20;
        wr(CFG, 32'h0);
        checkPin({7'h0, flt}, 8'h01);
        wr(CFG, 32'h200);
        checkPin({7'h0, flt}, 8'h00);
    endtask
    task periph;
        ext <= 8'h19;
        serialTx <= 1'b1;
        serialTxEnable <= 1'b1;
        wr(CFG, 32'h40000);
        @(posedge clk);
        checkPin(pinOe, 8'h04);
        checkPin(pinOut & 8'h04, 8'h04);
        checkPin({rx, tmr, eZ, 5'h0}, 8'he0);
        wr(CFG, 32'h40033);
        @(posedge clk);
        checkPin({rx, tmr, eZ, 5'h0}, 8'h80);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        resetValues();
        driveOut();
        readIn();
        oscMode();
        faultSel();
        periph();
        conclude();
    end
    initial begin
        #20000;
        errors++;
        conclude();
    end
endmodule
